// File: osc_defs.vh
// Overview of operation
// - Read-only 3-bit active source field reports the clock now running.
// - Writable 3-bit requested source field; code 100 reserved, software avoids it.
// - Requested source loads from configuration in the first enabled cycle after reset; other fields except the PLL settled status reset to zero.
// - Bits 15, 11, 4, 2 and 1 are unimplemented and read as zero.
// - Freeze bit with fail-safe configuration 1 locks clock and PLL settings.
// - Pin-map lock output follows the pin-map freeze bit.
// - Control register writes accepted only after an unlock sequence.
// - Software writing one to a clear failure flag acts like a real failure.
`ifndef OSC_DEFS_VH
`define OSC_DEFS_VH
`define OSC_ADDR_CTRL 4'h0
`define OSC_ADDR_STATUS 4'h1
`define OSC_ADDR_MASK 4'h2
`define OSC_ADDR_UNLOCK 4'h3
`define OSC_KEY1 16'h0057
`define OSC_KEY2 16'h00aa
`define OSC_ACT_LSB 12
`define OSC_REQ_LSB 8
`define OSC_FRZ_BIT 7
`define OSC_PIN_BIT 6
`define OSC_PLLOK_BIT 5
`define OSC_FAIL_BIT 3
`define OSC_SWREQ_BIT 0
`define OSC_SRC_FRC 3'h0
`define OSC_SRC_FAST_RC_MULTIPLIED 3'h1
`define OSC_SRC_PRIPLL 3'h3
`define OSC_SRC_RSVD 3'h4
`define OSC_EV_DONE 0
`define OSC_EV_FAIL 1
`define OSC_EV_REJ 2
`define OSC_SWITCH_NS 100
`define OSC_SWITCH_CYC ((`OSC_SWITCH_NS + 9) / 10)
`endif

// File: osc_unlock.v
`timescale 1ns/10ps
`include "osc_defs.vh"
module osc_unlock (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire wr_en,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire consume,
  output wire unlocked
);
  reg [1:0] st_reg;
  // Two key writes arm one control write; any other write to the unlock address disarms
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= 2'h0;
    end else if (ce) begin
      if (consume) begin
        st_reg <= 2'h0;
      end else if (wr_en && addr == `OSC_ADDR_UNLOCK) begin
        if (wdata == `OSC_KEY1) begin
          st_reg <= 2'h1;
        end else if (wdata == `OSC_KEY2 && st_reg == 2'h1) begin
          st_reg <= 2'h2;
        end else begin
          st_reg <= 2'h0;
        end
      end
    end
  end
  assign unlocked = (st_reg == 2'h2);
endmodule // osc_unlock

// File: osc_switch.v
`timescale 1ns/10ps
`include "osc_defs.vh"
module osc_switch #(
  parameter SWITCH_CYC = `OSC_SWITCH_CYC
) (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire start,
  output wire busy,
  output wire done
);
  reg [15:0] cnt_reg;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
    end else if (ce) begin
      if (start && cnt_reg == 16'h0000) begin
        cnt_reg <= SWITCH_CYC[15:0];
      end else if (cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end
  assign busy = (cnt_reg != 16'h0000);
  assign done = ce && (cnt_reg == 16'h0001);
endmodule // osc_switch

// File: osc_ctrl.v
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`include "osc_defs.vh"
module osc_ctrl #(
  parameter SWITCH_CYC = `OSC_SWITCH_CYC
) (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [15:0] rdata,
  input wire [2:0] cfg_source,
  input wire fail_safe_mode_cfg,
  input wire pll_locked,
  input wire pll_timer_done,
  input wire pll_enabled,
  input wire osc_fail_detect,
  output wire clock_config_locked,
  output wire pin_map_locked,
  output wire osc_fail_trap,
  output wire [2:0] clock_source,
  output wire irq
);
  reg [2:0] active_source_select_reg;
  reg [2:0] pending_source_select_reg;
  reg [2:0] target_reg;
  reg clock_config_freeze_reg;
  reg pin_map_freeze_reg;
  reg osc_failure_flag_reg;
  reg switch_request_reg;
  reg cfg_loaded_reg;
  reg [2:0] irq_status_reg;
  reg [2:0] irq_mask_reg;
  reg [2:0] irq_status_next;
  wire unlocked;
  wire ctrl_wr;
  wire sw_busy;
  wire sw_done;
  wire sw_start;
  wire pll_settled;
  wire bad_pair;
  wire [2:0] req_new;
  wire frozen;

  osc_unlock u_unlock (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .wr_en(wr_en),
    .addr(addr),
    .wdata(wdata),
    .consume(ctrl_wr),
    .unlocked(unlocked)
  );

  osc_switch #(.SWITCH_CYC(SWITCH_CYC)) u_switch (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .start(sw_start),
    .busy(sw_busy),
    .done(sw_done)
  );

  // Frozen writes still update the pin-map and failure bits but cannot clear the freeze bit; a write without unlock is dropped whole
  assign ctrl_wr = wr_en && addr == `OSC_ADDR_CTRL && unlocked;
  assign frozen = clock_config_freeze_reg && fail_safe_mode_cfg;
  assign req_new = wdata[`OSC_REQ_LSB+2:`OSC_REQ_LSB];
  assign bad_pair = (active_source_select_reg == `OSC_SRC_PRIPLL && pending_source_select_reg == `OSC_SRC_FAST_RC_MULTIPLIED) ||
                    (active_source_select_reg == `OSC_SRC_FAST_RC_MULTIPLIED && pending_source_select_reg == `OSC_SRC_PRIPLL);
  assign sw_start = switch_request_reg && !sw_busy && !bad_pair &&
                    pending_source_select_reg != `OSC_SRC_RSVD;
  assign pll_settled = pll_enabled && (pll_locked || pll_timer_done);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      active_source_select_reg <= 3'h0;
      pending_source_select_reg <= 3'h0;
      target_reg <= 3'h0;
      clock_config_freeze_reg <= 1'b0;
      pin_map_freeze_reg <= 1'b0;
      osc_failure_flag_reg <= 1'b0;
      switch_request_reg <= 1'b0;
      cfg_loaded_reg <= 1'b0;
    end else if (ce) begin
      // Strap is caught after release, never under the async reset
      cfg_loaded_reg <= 1'b1;
      if (!cfg_loaded_reg) begin
        pending_source_select_reg <= cfg_source;
      end else if (ctrl_wr && !frozen && req_new != `OSC_SRC_RSVD) begin
        pending_source_select_reg <= req_new;
      end
      if (ctrl_wr) begin
        clock_config_freeze_reg <= wdata[`OSC_FRZ_BIT] | frozen;
        pin_map_freeze_reg <= wdata[`OSC_PIN_BIT];
      end
      // Hardware failure wins over a software clear in the same cycle
      if (osc_fail_detect) begin
        osc_failure_flag_reg <= 1'b1;
      end else if (ctrl_wr) begin
        osc_failure_flag_reg <= wdata[`OSC_FAIL_BIT];
      end
      if (sw_start) begin
        target_reg <= pending_source_select_reg;
      end
      if (sw_done) begin
        active_source_select_reg <= target_reg;
        switch_request_reg <= 1'b0;
      end else if (switch_request_reg && !sw_busy && (bad_pair || pending_source_select_reg == `OSC_SRC_RSVD)) begin
        switch_request_reg <= 1'b0;
      end else if (ctrl_wr && wdata[`OSC_SWREQ_BIT] && !frozen) begin
        switch_request_reg <= 1'b1;
      end
    end
  end

  always @* begin
    irq_status_next = irq_status_reg;
    if (wr_en && addr == `OSC_ADDR_STATUS) begin
      irq_status_next = irq_status_next & ~wdata[2:0];
    end
    if (sw_done) begin
      irq_status_next[`OSC_EV_DONE] = 1'b1;
    end
    if (osc_fail_detect || (ctrl_wr && wdata[`OSC_FAIL_BIT] && !osc_failure_flag_reg)) begin
      irq_status_next[`OSC_EV_FAIL] = 1'b1;
    end
    if (switch_request_reg && !sw_busy && bad_pair) begin
      irq_status_next[`OSC_EV_REJ] = 1'b1;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_status_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else if (ce) begin
      irq_status_reg <= irq_status_next;
      if (wr_en && addr == `OSC_ADDR_MASK) begin
        irq_mask_reg <= wdata[2:0];
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      if (rd_en && addr == `OSC_ADDR_CTRL) begin
        rdata <= {1'b0, active_source_select_reg, 1'b0, pending_source_select_reg,
                  clock_config_freeze_reg, pin_map_freeze_reg, pll_settled, 1'b0,
                  osc_failure_flag_reg, 2'b00, switch_request_reg};
      end else if (rd_en && addr == `OSC_ADDR_STATUS) begin
        rdata <= {13'h0000, irq_status_reg};
      end else if (rd_en && addr == `OSC_ADDR_MASK) begin
        rdata <= {13'h0000, irq_mask_reg};
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  assign clock_config_locked = frozen;
  assign pin_map_locked = pin_map_freeze_reg;
  assign osc_fail_trap = osc_failure_flag_reg;
  assign clock_source = active_source_select_reg;
  assign irq = |(irq_status_reg & irq_mask_reg);
endmodule // osc_ctrl

// File: osc_ctrl_checker.sv
`timescale 1ns/10ps
module osc_ctrl_checker (
  input wire mclk, rst, ce, wr_en, rd_en, fail_safe_mode_cfg, pll_locked, pll_timer_done, pll_enabled,
  input wire osc_fail_detect, clock_config_locked, pin_map_locked, osc_fail_trap,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire [15:0] rdata,
  input wire [2:0] clock_source
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire rc = rd_en && ce && addr == 4'h0;
  a_rsvd_bits: assert property (rc |=> (rdata & 16'h8816) == 16'h0)
    else $error("unimplemented bits read high");
  a_clk_lock: assert property (rc |=> clock_config_locked == (rdata[7] & fail_safe_mode_cfg))
    else $error("clock lock disagrees with freeze bit");
  a_pin_lock: assert property (rc |=> pin_map_locked == rdata[6])
    else $error("pin lock disagrees with freeze bit");
  a_pll_flag: assert property (rc |=> rdata[5] == $past(pll_enabled & (pll_locked | pll_timer_done)))
    else $error("settled flag wrong");
  a_src_legal: assert property (clock_source != 3'h4)
    else $error("reserved active source");
  a_fail_trap: assert property (ce && osc_fail_detect |=> osc_fail_trap)
    else $error("failure not trapped");
  a_trap_cause: assert property ($rose(osc_fail_trap) |-> $past(osc_fail_detect) || $past(wr_en && addr == 4'h0 && wdata[3]))
    else $error("trap without cause");
  a_no_pll_hop: assert property (!($past(clock_source) == 3'h3 && clock_source == 3'h1) &&
    !($past(clock_source) == 3'h1 && clock_source == 3'h3))
    else $error("direct hop between multiplied sources");
  a_reset_zero: assert property (disable iff (1'b0) rst |-> clock_source == 3'h0 && !osc_fail_trap &&
    !pin_map_locked && rdata == 16'h0)
    else $error("outputs not cleared in reset");
endmodule // osc_ctrl_checker
bind osc_ctrl osc_ctrl_checker chk (.mclk, .rst, .ce, .wr_en, .rd_en, .fail_safe_mode_cfg, .pll_locked, .pll_timer_done,
  .pll_enabled, .osc_fail_detect, .clock_config_locked, .pin_map_locked, .osc_fail_trap, .addr, .wdata, .rdata, .clock_source);

// File: oscillator_source_control_tb_top.sv
`timescale 1ns/10ps
module oscillator_source_control_tb_top;
  reg mclk = 0, rst = 0, ce = 1, wr_en = 0, rd_en = 0, fsm = 1, pll_locked = 1, pll_timer_done = 0;
  reg pll_enabled = 1, osc_fail_detect = 0;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0;
  reg [2:0] cfg_source = 3'h2;
  wire [15:0] rdata;
  wire ccl, pml, trap, irq;
  wire [2:0] clock_source;
  integer miscompares = 0, cmp_count = 0, cyc = 0;
  osc_ctrl #(.SWITCH_CYC(2)) uut (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .cfg_source(cfg_source), .fail_safe_mode_cfg(fsm), .pll_locked(pll_locked),
    .pll_timer_done(pll_timer_done), .pll_enabled(pll_enabled), .osc_fail_detect(osc_fail_detect),
    .clock_config_locked(ccl), .pin_map_locked(pml), .osc_fail_trap(trap), .clock_source(clock_source), .irq(irq));
  initial forever #5 mclk = ~mclk;
  task summarize;
    begin
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Hang guard, far above the under two hundred cycles the run needs
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  task chk(input string n, input [15:0] e, input [15:0] s);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("ERROR %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  // Strobes stay up until the next call, so calls run back to back
  task op(input w, input r, input [3:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      wr_en <= w;
      rd_en <= r;
      addr <= a;
      wdata <= d;
    end
  endtask
  task rd(input [3:0] a, input [15:0] e);
    begin
      op(1'b0, 1'b1, a, 16'h0);
      op(1'b0, 1'b0, a, 16'h0);
      #1 chk("rdata", e, rdata);
    end
  endtask
  task key;
    begin
      op(1'b1, 1'b0, 4'h3, 16'h0057);
      op(1'b1, 1'b0, 4'h3, 16'h00aa);
    end
  endtask
  task sw(input [15:0] d);
    begin
      key;
      op(1'b1, 1'b0, 4'h0, d);
      repeat (8) op(1'b0, 1'b0, 4'h0, 16'h0);
    end
  endtask
  task clr;
    begin
      op(1'b1, 1'b0, 4'h1, 16'h0007);
      op(1'b0, 1'b0, 4'h0, 16'h0);
    end
  endtask
  initial begin
    // Reset rises just after time zero so the async branch really fires
    #1 rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) op(1'b0, 1'b0, 4'h0, 16'h0);
    rd(4'h0, 16'h0220);
    rd(4'h1, 16'h0);
    rd(4'h7, 16'h0);
    op(1'b1, 1'b0, 4'h0, 16'h0701);
    rd(4'h0, 16'h0220);
    sw(16'h0400);
    rd(4'h0, 16'h0220);
    op(1'b1, 1'b0, 4'h2, 16'h0007);
    key;
    op(1'b1, 1'b0, 4'h0, 16'h0301);
    rd(4'h0, 16'h0321);
    repeat (8) op(1'b0, 1'b0, 4'h0, 16'h0);
    rd(4'h0, 16'h3320);
    #1 chk("irq", 16'h1, {15'h0, irq});
    clr;
    #1 chk("irq", 16'h0, {15'h0, irq});
    sw(16'h0101);
    rd(4'h0, 16'h3120);
    rd(4'h1, 16'h0004);
    clr;
    sw(16'h0001);
    sw(16'h0101);
    rd(4'h0, 16'h1120);
    clr;
    sw(16'h1108);
    #1 chk("trap", 16'h1, {15'h0, trap});
    rd(4'h1, 16'h0002);
    sw(16'h1100);
    #1 chk("trap", 16'h0, {15'h0, trap});
    clr;
    @(posedge mclk) osc_fail_detect <= 1'b1;
    @(posedge mclk) osc_fail_detect <= 1'b0;
    op(1'b1, 1'b0, 4'h2, 16'h0);
    op(1'b0, 1'b0, 4'h0, 16'h0);
    #1 chk("trap", 16'h1, {15'h0, trap});
    #1 chk("irq", 16'h0, {15'h0, irq});
    rd(4'h1, 16'h0002);
    // Clock enable low: a mask write must be lost
    @(posedge mclk) ce <= 1'b0;
    op(1'b1, 1'b0, 4'h2, 16'h0007);
    op(1'b0, 1'b0, 4'h0, 16'h0);
    ce <= 1'b1;
    rd(4'h2, 16'h0000);
    sw(16'h11c0);
    #1 chk("locks", 16'h3, {14'h0, ccl, pml});
    sw(16'h00c1);
    rd(4'h0, 16'h11e0);
    @(posedge mclk) pll_locked <= 1'b0;
    repeat (3) op(1'b0, 1'b0, 4'h0, 16'h0);
    rd(4'h0, 16'h11c0);
    @(posedge mclk) pll_timer_done <= 1'b1;
    repeat (2) op(1'b0, 1'b0, 4'h0, 16'h0);
    rd(4'h0, 16'h11e0);
    @(posedge mclk) pll_enabled <= 1'b0;
    repeat (2) op(1'b0, 1'b0, 4'h0, 16'h0);
    rd(4'h0, 16'h11c0);
    summarize;
  end
endmodule // oscillator_source_control_tb_top
